//--- aros_pkg.sv
// How it works
// - default limits 100, 1000, 10000 ppm.
// - three ranges, zero based, upper limit each.
// - reset mode is automatic ranging.
// - auto: above active limit, step up.
// - auto: step down below 85% lower limit.
// - range change updates both outputs together.
// - modes auto, fixed low, medium, high.
// - fixed range over limit clamps full scale.
// - readback reports true full-precision concentration.
// - air calibration uses fixed 0-25% range.
// - limits valid only when strictly increasing.
// - ppm limits to 250000; percent above 10000.
// - output linear: zero 0V/4mA, limit 1V/20mA.
// - range id levels per range, cal 1V/20mA.
// - completed function or analyze returns to analyze.
// - confirm stores limits; escape applies mode.
package aros_pkg;

    localparam int          LIM_W       = 18;
    localparam int          DAC_W       = 12;
    localparam logic [17:0] LIM_LO_RST  = 18'h00064;
    localparam logic [17:0] LIM_MED_RST = 18'h003e8;
    localparam logic [17:0] LIM_HI_RST  = 18'h02710;
    localparam logic [17:0] PPM_MAX     = 18'h3d090;
    localparam logic [17:0] PCT_THRESH  = 18'h02710;
    localparam logic [7:0]  HYST_PCT    = 8'h55;
    localparam logic [7:0]  PCT_FULL    = 8'h64;
    // dac codes: 0.25 mV and 5 uA per step
    localparam logic [11:0] DAC_FS      = 12'hfa0;
    localparam logic [11:0] MA_ZERO     = 12'h320;
    localparam logic [11:0] RID_V_LO    = 12'h3e8;
    localparam logic [11:0] RID_V_MED   = 12'h7d0;
    localparam logic [11:0] RID_V_HI    = 12'hbb8;
    localparam logic [11:0] RID_MA_LO   = 12'h640;
    localparam logic [11:0] RID_MA_MED  = 12'h960;
    localparam logic [11:0] RID_MA_HI   = 12'hc80;

    localparam logic [7:0]  OFF_CTRL    = 8'h00;
    localparam logic [7:0]  OFF_CMD     = 8'h04;
    localparam logic [7:0]  OFF_LIM_LO  = 8'h08;
    localparam logic [7:0]  OFF_LIM_MED = 8'h0c;
    localparam logic [7:0]  OFF_LIM_HI  = 8'h10;
    localparam logic [7:0]  OFF_STATUS  = 8'h14;
    localparam logic [7:0]  OFF_CONC    = 8'h18;
    localparam int          CTRL_CAL    = 2;
    localparam int          CMD_CONFIRM = 0;
    localparam int          CMD_ESCAPE  = 1;
    localparam int          CMD_ANALYZE = 2;

    typedef enum logic [1:0] {
        AUTO_RANGE_MODE         = 2'h0,
        FIXED_LOW_RANGE_MODE    = 2'h1,
        FIXED_MEDIUM_RANGE_MODE = 2'h2,
        FIXED_HIGH_RANGE_MODE   = 2'h3
    } aros_mode_type;

    typedef enum logic [1:0] {
        RNG_LO  = 2'h0,
        RNG_MED = 2'h1,
        RNG_HI  = 2'h2,
        RNG_CAL = 2'h3
    } aros_range_type;

    typedef enum logic [1:0] {
        ST_ANALYZE = 2'b01,
        ST_EDIT    = 2'b10
    } aros_state_type;

    typedef struct packed {
        logic [11:0] volt;
        logic [11:0] amp;
    } aros_dac_type;

    localparam aros_mode_type MODE_RST = AUTO_RANGE_MODE;

endpackage

//--- aros_selector.sv
`timescale 1ns/10ps
module aros_selector
    import aros_pkg::*;
(
    input  wire logic         REF_CLK_I,
    input  wire logic         RESETN_I,
    input  wire logic         CYC_I,
    input  wire logic         STB_I,
    input  wire logic         WE_I,
    input  wire logic [7:0]   ADR_I,
    input  wire logic [3:0]   SEL_I,
    input  wire logic [31:0]  DAT_I,
    output logic      [31:0]  DAT_O,
    output logic              ACK_O,
    input  wire logic [17:0]  CONC_I,
    input  wire logic         CONC_VALID_I,
    output aros_dac_type      CONC_DAC_O,
    output aros_dac_type      RANGE_ID_DAC_O,
    output logic [1:0]        RANGE_O,
    output logic              PERCENT_UNITS_O
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [17:0]    lim_reg [3];
    logic [17:0]    edit_reg [3];
    aros_mode_type  mode_reg;
    aros_mode_type  edit_mode_reg;
    aros_range_type act_reg;
    aros_state_type state_reg;
    logic           cal_reg;
    logic           lim_err_reg;
    logic [17:0]    conc_reg;
    logic           ack_reg;
    logic [31:0]    rdata_reg;
    aros_dac_type   conc_dac_reg;
    aros_dac_type   rid_dac_reg;
    logic [1:0]     range_out_reg;
    logic           pct_reg;

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    wire        wb_req   = CYC_I & STB_I & ~ack_reg;
    wire        wb_wr    = wb_req & WE_I;
    wire        hit_ctrl = ADR_I == OFF_CTRL;
    wire        hit_cmd  = ADR_I == OFF_CMD;
    wire        hit_lo   = ADR_I == OFF_LIM_LO;
    wire        hit_med  = ADR_I == OFF_LIM_MED;
    wire        hit_hi   = ADR_I == OFF_LIM_HI;
    wire        hit_stat = ADR_I == OFF_STATUS;
    wire        hit_conc = ADR_I == OFF_CONC;
    wire [31:0] lane_m   = {{8{SEL_I[3]}}, {8{SEL_I[2]}},
                            {8{SEL_I[1]}}, {8{SEL_I[0]}}};
    wire        wr_ctrl  = wb_wr & hit_ctrl;
    wire        wr_lim   = wb_wr & (hit_lo | hit_med | hit_hi);
    wire        wr_cmd   = wb_wr & hit_cmd;
    wire [31:0] cmd_w    = DAT_I & lane_m;
    wire        do_conf  = wr_cmd & cmd_w[CMD_CONFIRM];
    wire        do_esc   = wr_cmd & cmd_w[CMD_ESCAPE];
    wire        do_anlz  = wr_cmd & cmd_w[CMD_ANALYZE];

    wire [31:0] ctrl_rd  = {29'h0, cal_reg, edit_mode_reg};
    wire [31:0] stat_rd  = {25'h0, pct_reg, lim_err_reg,
                            state_reg == ST_EDIT, mode_reg, range_out_reg};
    wire [31:0] rd_mux   =
        hit_ctrl ? ctrl_rd :
        hit_lo   ? {14'h0, edit_reg[0]} :
        hit_med  ? {14'h0, edit_reg[1]} :
        hit_hi   ? {14'h0, edit_reg[2]} :
        hit_stat ? stat_rd :
        hit_conc ? {14'h0, conc_reg} :
        32'h0;

    // merged write data for the limit entry being written
    wire [1:0]  lim_idx  = hit_lo ? 2'h0 : hit_med ? 2'h1 : 2'h2;
    wire [31:0] lim_old  = {14'h0, edit_reg[lim_idx]};
    wire [31:0] lim_mrg  = (lim_old & ~lane_m) | (DAT_I & lane_m);
    // ppm entries stop at the top of the measuring span
    wire [17:0] lim_wr   = lim_mrg > {14'h0, PPM_MAX} ?
                           PPM_MAX : lim_mrg[17:0];
    wire [31:0] ctrl_mrg = (ctrl_rd & ~lane_m) | (DAT_I & lane_m);

    // ------------------------------------------------------------
    // limit check and range tables
    // ------------------------------------------------------------
    // a zero low limit would leave the low range without a span
    wire lim_ok = edit_reg[0] != 18'h0 &&
                  edit_reg[0] < edit_reg[1] &&
                  edit_reg[1] < edit_reg[2];

    // mode selects one of the three programmed ranges
    wire aros_range_type fix_rng = aros_range_type'(mode_reg - 2'h1);

    wire [17:0] up_lim   = lim_reg[act_reg[1:0] == 2'h3 ? 2'h2 :
                                   act_reg[1:0]];
    wire [1:0]  dn_idx   = act_reg == RNG_HI ? 2'h1 : 2'h0;
    wire [17:0] dn_lim   = lim_reg[dn_idx];
    wire [25:0] h_lhs    = 26'(CONC_I) * 26'(PCT_FULL);
    wire [25:0] h_rhs    = 26'(dn_lim) * 26'(HYST_PCT);
    wire        go_up    = CONC_I > up_lim && act_reg != RNG_HI;
    wire        go_dn    = act_reg != RNG_LO && h_lhs < h_rhs;

    aros_range_type auto_next;
    always_comb begin
        auto_next = act_reg;
        if (go_up) begin
            auto_next = aros_range_type'(act_reg + 2'h1);
        end else if (go_dn) begin
            auto_next = aros_range_type'(act_reg - 2'h1);
        end
    end

    // ------------------------------------------------------------
    // output scaling
    // ------------------------------------------------------------
    // the calibration range overrides whatever range is active
    wire aros_range_type eff_rng = cal_reg ? RNG_CAL : act_reg;
    wire [17:0] span     = cal_reg ? PPM_MAX : up_lim;
    wire [29:0] num      = 30'(conc_reg) * 30'(DAC_FS);
    wire [29:0] quo      = num / 30'(span);
    // over the span the output sits at full scale, not wrapped
    wire        over     = conc_reg >= span;
    wire [11:0] v_code   = over ? DAC_FS : quo[11:0];
    wire [13:0] v_x4     = {v_code, 2'b00};
    wire [13:0] v_div    = v_x4 / 14'h5;
    wire [11:0] ma_code  = MA_ZERO + v_div[11:0];

    aros_dac_type rid_next;
    always_comb begin
        unique case (eff_rng)
            RNG_LO:  rid_next = '{volt: RID_V_LO,  amp: RID_MA_LO};
            RNG_MED: rid_next = '{volt: RID_V_MED, amp: RID_MA_MED};
            RNG_HI:  rid_next = '{volt: RID_V_HI,  amp: RID_MA_HI};
            RNG_CAL: rid_next = '{volt: DAC_FS,    amp: DAC_FS};
        endcase
    end

    // ------------------------------------------------------------
    // bus slave
    // ------------------------------------------------------------
    // every request answers one cycle later; writes land at the taking edge
    wire [31:0] rdata_next = wb_req && !WE_I ? rd_mux : 32'h0;

    always_ff @(posedge REF_CLK_I) begin
        if (!RESETN_I) begin
            ack_reg   <= 1'b0;
            rdata_reg <= 32'h0;
        end else begin
            ack_reg   <= wb_req;
            rdata_reg <= rdata_next;
        end
    end

    // ------------------------------------------------------------
    // range function: entry, confirm, escape, analyze
    // ------------------------------------------------------------
    // analyze outranks confirm, confirm outranks escape
    wire        in_edit  = state_reg == ST_EDIT;
    wire        ed_anlz  = in_edit & do_anlz;
    wire        ed_conf  = in_edit & ~do_anlz & do_conf;
    wire        ed_esc   = in_edit & ~do_anlz & ~do_conf & do_esc;
    wire        ed_leave = ed_anlz | ed_conf | ed_esc;
    wire        lim_take = ed_conf & lim_ok;
    wire        lim_rej  = ed_conf & ~lim_ok;
    // every exit but a good confirm drops the limit edits
    wire        ed_back  = ed_anlz | ed_esc | lim_rej;
    // rewriting the applied mode opens no entry
    wire        mode_chg = wr_ctrl & (ctrl_mrg[1:0] != edit_mode_reg);

    aros_state_type state_next;
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_ANALYZE: begin
                if (wr_lim || mode_chg) begin
                    state_next = ST_EDIT;
                end
            end
            ST_EDIT: begin
                if (ed_leave) begin
                    state_next = ST_ANALYZE;
                end
            end
            default: begin
                state_next = ST_ANALYZE;
            end
        endcase
    end

    wire aros_mode_type mode_next      =
        lim_take | ed_esc ? edit_mode_reg :
        mode_reg;
    wire aros_mode_type edit_mode_next =
        ed_anlz | lim_rej ? mode_reg :
        wr_ctrl           ? aros_mode_type'(ctrl_mrg[1:0]) :
        edit_mode_reg;
    // rejected entry: old limits stay, flag holds until a good confirm
    wire                lim_err_next   = lim_rej | (lim_err_reg & ~lim_take);
    // calibration range takes effect at once, outside any entry
    wire                cal_next       = wr_ctrl ? ctrl_mrg[CTRL_CAL] : cal_reg;

    always_ff @(posedge REF_CLK_I) begin
        if (!RESETN_I) begin
            state_reg     <= ST_ANALYZE;
            mode_reg      <= MODE_RST;
            edit_mode_reg <= MODE_RST;
            cal_reg       <= 1'b0;
            lim_err_reg   <= 1'b0;
        end else begin
            state_reg     <= state_next;
            mode_reg      <= mode_next;
            edit_mode_reg <= edit_mode_next;
            cal_reg       <= cal_next;
            lim_err_reg   <= lim_err_next;
        end
    end

    // ------------------------------------------------------------
    // limit storage: live copy and edit copy per range
    // ------------------------------------------------------------
    // the bus reads the edit copy; only the live copy sets the outputs
    for (genvar g = 0; g < 3; g++) begin : g_lim
        localparam logic [17:0] RST_VAL = g == 0 ? LIM_LO_RST :
                                          g == 1 ? LIM_MED_RST : LIM_HI_RST;
        wire wr_this = wr_lim & (lim_idx == 2'(g));
        always_ff @(posedge REF_CLK_I) begin
            if (!RESETN_I) begin
                lim_reg[g]  <= RST_VAL;
                edit_reg[g] <= RST_VAL;
            end else begin
                if (lim_take) begin
                    lim_reg[g] <= edit_reg[g];
                end
                if (ed_back) begin
                    edit_reg[g] <= lim_reg[g];
                end else if (wr_this) begin
                    edit_reg[g] <= lim_wr;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // active range selection
    // ------------------------------------------------------------
    aros_range_type act_next;
    always_comb begin
        act_next = act_reg;
        if (mode_reg != AUTO_RANGE_MODE) begin
            // a fixed mode pins the range every cycle, samples or not
            act_next = fix_rng;
        end else if (CONC_VALID_I) begin
            // one step per sample keeps each move to an adjacent range
            act_next = auto_next;
        end
    end
    wire [17:0] conc_next = CONC_VALID_I ? CONC_I : conc_reg;

    always_ff @(posedge REF_CLK_I) begin
        if (!RESETN_I) begin
            act_reg  <= RNG_LO;
            conc_reg <= 18'h0;
        end else begin
            act_reg  <= act_next;
            conc_reg <= conc_next;
        end
    end

    // ------------------------------------------------------------
    // analog output codes
    // ------------------------------------------------------------
    aros_dac_type conc_dac_next;
    logic         pct_next;
    always_comb begin
        conc_dac_next = '{volt: v_code, amp: ma_code};
        pct_next      = conc_reg > PCT_THRESH;
    end

    // both outputs load from the same range in one edge
    always_ff @(posedge REF_CLK_I) begin
        if (!RESETN_I) begin
            conc_dac_reg  <= '{volt: 12'h000, amp: MA_ZERO};
            rid_dac_reg   <= '{volt: RID_V_LO, amp: RID_MA_LO};
            range_out_reg <= 2'h0;
            pct_reg       <= 1'b0;
        end else begin
            conc_dac_reg  <= conc_dac_next;
            rid_dac_reg   <= rid_next;
            range_out_reg <= eff_rng;
            pct_reg       <= pct_next;
        end
    end

    assign DAT_O           = rdata_reg;
    assign ACK_O           = ack_reg;
    assign CONC_DAC_O      = conc_dac_reg;
    assign RANGE_ID_DAC_O  = rid_dac_reg;
    assign RANGE_O         = range_out_reg;
    assign PERCENT_UNITS_O = pct_reg;

endmodule

//--- aros_recorder_model.sv
`timescale 1ns/10ps
module aros_recorder_model
    import aros_pkg::*;
(
    input  wire logic         clk_i,
    input  aros_dac_type      conc_dac_i,
    input  aros_dac_type      range_id_dac_i,
    output int                conc_uv_o,
    output int                conc_ua_o,
    output int                rid_uv_o
);
    // recorder input sampling: 250 uV and 5 uA per code step
    always @(posedge clk_i) begin
        conc_uv_o <= 250 * int'(conc_dac_i.volt);
        conc_ua_o <= 5 * int'(conc_dac_i.amp);
        rid_uv_o  <= 250 * int'(range_id_dac_i.volt);
    end
endmodule

//--- aros_selector_properties.sv
`timescale 1ns/10ps
module aros_selector_properties
    import aros_pkg::*;
(
    input wire logic          REF_CLK_I,
    input wire logic          RESETN_I,
    input wire logic          CYC_I,
    input wire logic          STB_I,
    input wire logic [17:0]   CONC_I,
    input wire logic          CONC_VALID_I,
    input wire logic [31:0]   DAT_O,
    input wire logic          ACK_O,
    input aros_dac_type       CONC_DAC_O,
    input aros_dac_type       RANGE_ID_DAC_O,
    input wire logic [1:0]    RANGE_O,
    input wire logic          PERCENT_UNITS_O
);
    default clocking @(posedge REF_CLK_I); endclocking
    default disable iff (!RESETN_I);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    logic [1:0]  quiet_reg;
    wire  [11:0] rid_v   = RID_V_LO * ({10'h0, RANGE_O} + 12'h1);
    wire  [11:0] rid_a   = MA_ZERO * ({10'h0, RANGE_O} + 12'h2);
    wire  [13:0] amp_exp = {2'h0, MA_ZERO} + ({2'h0, CONC_DAC_O.volt} * 14'h4) / 14'h5;
    // range may only move shortly after a sample or a bus request
    always_ff @(posedge REF_CLK_I) begin
        if (!RESETN_I || CONC_VALID_I || (CYC_I && STB_I))
            quiet_reg <= 2'h0;
        else if (quiet_reg != 2'h3)
            quiet_reg <= quiet_reg + 2'h1;
    end
    sequence s_take;
        CYC_I && STB_I && !ACK_O;
    endsequence
    sequence s_zero_sample;
        CONC_VALID_I && CONC_I == 18'h0;
    endsequence
    AST_ACK_NEXT: assert property (s_take |=> ACK_O) else $error("ack late");
    AST_ACK_PULSE: assert property (ACK_O |=> !ACK_O) else $error("ack too long");
    AST_DAT_IDLE: assert property (!ACK_O |-> DAT_O == 32'h0) else $error("data outside ack");
    AST_RID_LEVELS: assert property (
        RANGE_ID_DAC_O.volt == rid_v && RANGE_ID_DAC_O.amp == rid_a) else $error("range id level");
    AST_RANGE_TOGETHER: assert property (
        $changed(RANGE_O) |-> $changed(RANGE_ID_DAC_O)) else $error("range id lags");
    AST_AMP_TRACK: assert property ({2'h0, CONC_DAC_O.amp} == amp_exp)
        else $error("current output not linear");
    AST_FULL_SCALE: assert property (CONC_DAC_O.volt <= DAC_FS)
        else $error("voltage above full scale");
    AST_RESET_AUTO: assert property ($rose(RESETN_I) |-> RANGE_O == 2'h0 &&
        CONC_DAC_O.amp == MA_ZERO) else $error("reset range");
    AST_RANGE_CAUSE: assert property ($changed(RANGE_O) |-> quiet_reg <= 2'h1)
        else $error("range moved without cause");
    AST_PCT_UNITS: assert property (CONC_VALID_I |-> ##2
        PERCENT_UNITS_O == ($past(CONC_I, 2) > PCT_THRESH)) else $error("percent units");
    AST_ZERO_BASE: assert property (s_zero_sample |-> ##2
        CONC_DAC_O.volt == 12'h0 && CONC_DAC_O.amp == MA_ZERO) else $error("zero not at base");
endmodule

bind aros_selector aros_selector_properties u_props (.REF_CLK_I(REF_CLK_I),
    .RESETN_I(RESETN_I), .CYC_I(CYC_I), .STB_I(STB_I), .CONC_I(CONC_I),
    .CONC_VALID_I(CONC_VALID_I), .DAT_O(DAT_O), .ACK_O(ACK_O), .CONC_DAC_O(CONC_DAC_O),
    .RANGE_ID_DAC_O(RANGE_ID_DAC_O), .RANGE_O(RANGE_O), .PERCENT_UNITS_O(PERCENT_UNITS_O));

//--- aros_selector_tb.sv
`timescale 1ns/10ps
module aros_selector_tb
    import aros_pkg::*;
;
    logic         clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, vld = 0, ack, pct;
    logic [7:0]   adr = 8'h0;
    logic [3:0]   sel = 4'h0;
    logic [31:0]  dat = 32'h0, q, dat_o;
    logic [17:0]  conc = 18'h0;
    logic [1:0]   rng, pipe = 2'h0;
    aros_dac_type cdac, rdac;
    logic [50:0]  notes[$];
    int           fail_count = 0, comparisons = 0, uv, ua, rv, mode = 0, act = 0, cal = 0;
    int           lim[3] = '{100, 1000, 10000};
    int           seq[7] = '{150, 20000, 20000, 900, 800, 85, 80};

    always #10 clk = ~clk;

    aros_selector uut (.REF_CLK_I(clk), .RESETN_I(rst_n), .CYC_I(cyc), .STB_I(stb),
        .WE_I(we), .ADR_I(adr), .SEL_I(sel), .DAT_I(dat), .DAT_O(dat_o), .ACK_O(ack),
        .CONC_I(conc), .CONC_VALID_I(vld), .CONC_DAC_O(cdac), .RANGE_ID_DAC_O(rdac),
        .RANGE_O(rng), .PERCENT_UNITS_O(pct));
    aros_recorder_model rec (.clk_i(clk), .conc_dac_i(cdac), .range_id_dac_i(rdac),
        .conc_uv_o(uv), .conc_ua_o(ua), .rid_uv_o(rv));

    task results;
        $display("comparisons %0d failures %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task chk(input logic [50:0] got, input logic [50:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d; sel <= 4'hf;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = dat_o;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
        if (n >= 20) chk(1'b0, 1'b1);
    endtask

    task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        bus(1'b0, a, 32'h0);
        chk(q & m, e);
    endtask

    // ------------------------------------------------------------
    // sample driver with reference ranging
    // ------------------------------------------------------------
    task smp(input int c);
        int s, v, r;
        if (cal) begin
            r = 3; s = 250000;
        end else begin
            if (mode != 0) act = mode - 1;
            else if (act < 2 && c > lim[act]) act++;
            else if (act > 0 && c * 100 < 85 * lim[act - 1]) act--;
            r = act; s = lim[act];
        end
        v = (c >= s) ? 4000 : c * 4000 / s;
        notes.push_back({r[1:0], 12'(v), 12'(800 + v * 4 / 5), 12'(1000 * (r + 1)),
                         12'(800 * (r + 2)), c > 10000});
        @(posedge clk);
        conc <= c[17:0]; vld <= 1'b1;
        @(posedge clk);
        vld <= 1'b0;
        repeat (3) @(posedge clk);
        rd(OFF_CONC, c, 32'h3ffff);
    endtask

    // outputs settle two edges after the sample is taken
    always @(posedge clk) begin
        pipe <= {pipe[0], vld};
        if (pipe[1]) chk({rng, cdac, rdac, pct}, notes.pop_front());
    end

    initial begin
        #400000;
        fail_count++;
        results;
    end

    initial begin
        void'($urandom(98));
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        rd(OFF_CTRL, 32'h0, 32'h7);
        for (int i = 0; i < 3; i++) rd(8'(OFF_LIM_LO + 4 * i), lim[i], 32'h3ffff);
        rd(8'hfc, 32'h0, 32'hffffffff);
        foreach (seq[i]) smp(seq[i]);
        smp(0);
        repeat (6) smp($urandom % 12000);
        for (int m = 1; m < 4; m++) begin
            bus(1'b1, OFF_CTRL, m);
            bus(1'b1, OFF_CMD, 32'h2);
            mode = m;
            smp(250000);
            chk(uv, 1000000);
            chk(ua, 20000);
        end
        bus(1'b1, OFF_CTRL, 32'h0);
        bus(1'b1, OFF_CMD, 32'h2);
        mode = 0;
        smp(500);
        bus(1'b1, OFF_LIM_HI, 500);
        bus(1'b1, OFF_CMD, 32'h1);
        rd(OFF_STATUS, 32'h20, 32'h30);
        smp(5000);
        lim = '{200, 2000, 20000};
        for (int i = 0; i < 3; i++) bus(1'b1, 8'(OFF_LIM_LO + 4 * i), lim[i]);
        bus(1'b1, OFF_CMD, 32'h1);
        rd(OFF_STATUS, 32'h0, 32'h30);
        for (int i = 0; i < 3; i++) rd(8'(OFF_LIM_LO + 4 * i), lim[i], 32'h3ffff);
        smp(30000);
        smp(1500);
        // a dropped edit must not be applied by a later stray confirm
        bus(1'b1, OFF_LIM_LO, 50);
        bus(1'b1, OFF_CMD, 32'h4);
        bus(1'b1, OFF_CMD, 32'h1);
        smp(160);
        bus(1'b1, OFF_CTRL, 32'h4);
        cal = 1;
        smp(125000);
        smp(250000);
        chk(rv, 1000000);
        results;
    end
endmodule
